// >>> src/cips_priority_select.sv
/*
 core interrupt priority-select register with its two-level nesting tracker.
 assumes the core drives a same-clock sfr bus (byte and bit access), the
 enable-masked request vector, and pulses for vector taken and return.
*/
// Summary of operation
// R1 - bit 6 sets spi0 interrupt high level
// R2 - bit 5 sets timer 2 high level
// R3 - bit 4 sets uart0 high level
// R4 - bit 3 sets timer 1 high level
// R5 - bit 2 sets external interrupt 1 high
// R6 - bit 1 sets timer 0 high level
// R7 - bit 0 sets external interrupt 0 high
// R8 - at 0xb8 page 0, bit addressable
// R9 - bit 7 reads one; others reset zero
// R10 - high preempts low; low never preempts high
`timescale 1ns/10ps
`include "cips_defs.svh"
module core_interrupt_priority_select
   import cips_pkg::*;
#(
   parameter int NSRC = `CIPS_NUM_SRC
) (
   input wire logic clock, // system clock
   input wire logic rstn, // synchronous reset, active low
   input wire logic [7:0] sfr_addr, // sfr address
   input wire logic [7:0] sfr_page, // current sfr page
   input wire logic sfr_wr, // byte write strobe
   input wire logic sfr_rd, // read strobe
   input wire logic sfr_bit_wr, // single-bit write strobe
   input wire logic [2:0] sfr_bit_sel, // bit number for bit write
   input wire logic [7:0] sfr_wdata, // write data, bit value in bit 0
   input wire cips_pkg::cips_src_t irq_req, // enable-masked requests
   input wire logic irq_ack, // core vectors to irq_idx
   input wire logic irq_ret, // reti executed
   output logic [7:0] sfr_rdata, // read data, registered
   output logic sfr_hit, // read hit this register
   output cips_pkg::cips_src_t high_level, // priority bits to the core
   output logic irq_take, // request to vector now
   output cips_pkg::cips_idx_t irq_idx, // source to vector to
   output logic irq_is_high, // chosen source is high level
   output cips_pkg::cips_lvl_t active_lvl // level being serviced
);
   import cips_pkg::*;

   // the register has exactly seven level bits; other counts cannot map to it
   if (NSRC != `CIPS_NUM_SRC) begin : g_bad_nsrc
      $error("source count must match the register width");
   end

   logic [6:0] prio_q;
   logic in_low_q, in_high_q;
   logic hi_any, lo_any;
   cips_idx_t hi_idx, lo_idx;
   logic sel;
   logic [7:0] reg_view;

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] p);
      return (a == `CIPS_SFR_ADDR) && (p == `CIPS_SFR_PAGE);
   endfunction

   assign sel = addr_hit(sfr_addr, sfr_page); // R8
   assign reg_view = `CIPS_FIXED_MASK | {1'b0, prio_q}; // R9

   // bit writes to bit 7 fall through: fixed bit ignores writes
   always_ff @(posedge clock) begin
      if (!rstn) begin
         prio_q <= 7'(`CIPS_RESET_VAL & ~`CIPS_FIXED_MASK); // R9
      end else if (sel && sfr_wr) begin
         prio_q <= sfr_wdata[6:0]; // R1 R2 R3 R4 R5 R6 R7
      end else if (sel && sfr_bit_wr && sfr_bit_sel != `CIPS_BIT_FIXED) begin
         prio_q[sfr_bit_sel] <= sfr_wdata[0]; // R8
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         sfr_rdata <= 8'h00;
         sfr_hit <= 1'b0;
      end else begin
         sfr_hit <= sel && sfr_rd;
         sfr_rdata <= (sel && sfr_rd) ? reg_view : 8'h00; // R9
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         high_level <= '0;
      end else begin
         high_level[`CIPS_BIT_SPI0] <= prio_q[`CIPS_BIT_SPI0]; // R1
         high_level[`CIPS_BIT_T2] <= prio_q[`CIPS_BIT_T2]; // R2
         high_level[`CIPS_BIT_UART0] <= prio_q[`CIPS_BIT_UART0]; // R3
         high_level[`CIPS_BIT_T1] <= prio_q[`CIPS_BIT_T1]; // R4
         high_level[`CIPS_BIT_EXT1] <= prio_q[`CIPS_BIT_EXT1]; // R5
         high_level[`CIPS_BIT_T0] <= prio_q[`CIPS_BIT_T0]; // R6
         high_level[`CIPS_BIT_EXT0] <= prio_q[`CIPS_BIT_EXT0]; // R7
      end
   end

   cips_arbiter #(.NSRC(NSRC)) u_arb (
      .req(irq_req),
      .high_sel(prio_q),
      .hi_any(hi_any),
      .lo_any(lo_any),
      .hi_idx(hi_idx),
      .lo_idx(lo_idx)
   );

   // nesting: only a high request may interrupt a low routine
   always_ff @(posedge clock) begin
      if (!rstn) begin
         irq_take <= 1'b0;
         irq_idx <= '0;
         irq_is_high <= 1'b0;
      end else begin
         irq_take <= !irq_ack && !in_high_q && (hi_any || (lo_any && !in_low_q)); // R10
         irq_idx <= hi_any ? hi_idx : lo_idx; // R10
         irq_is_high <= hi_any;
      end
   end

   // a return closes the innermost level; high is always innermost
   always_ff @(posedge clock) begin
      if (!rstn) begin
         in_low_q <= 1'b0;
         in_high_q <= 1'b0;
      end else if (irq_ack) begin
         if (irq_is_high) begin
            in_high_q <= 1'b1;
         end else begin
            in_low_q <= 1'b1;
         end
      end else if (irq_ret) begin
         if (in_high_q) begin
            in_high_q <= 1'b0;
         end else begin
            in_low_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         active_lvl <= CIPS_LVL_NONE;
      end else begin
         active_lvl <= in_high_q ? CIPS_LVL_HIGH : (in_low_q ? CIPS_LVL_LOW : CIPS_LVL_NONE);
      end
   end
endmodule // core_interrupt_priority_select

// >>> src/cips_defs.svh
/*
 holds the address, page, bit positions, reset value and fixed bits of the
 core interrupt priority-select register. assumes nothing of its surroundings.
*/
`ifndef CIPS_DEFS_SVH
`define CIPS_DEFS_SVH
`define CIPS_SFR_ADDR 8'hb8
`define CIPS_SFR_PAGE 8'h00
`define CIPS_BIT_SPI0 3'h6
`define CIPS_BIT_T2 3'h5
`define CIPS_BIT_UART0 3'h4
`define CIPS_BIT_T1 3'h3
`define CIPS_BIT_EXT1 3'h2
`define CIPS_BIT_T0 3'h1
`define CIPS_BIT_EXT0 3'h0
`define CIPS_BIT_FIXED 3'h7
`define CIPS_RESET_VAL 8'h80
`define CIPS_FIXED_MASK 8'h80
`define CIPS_NUM_SRC 7
`endif

// >>> src/cips_pkg.sv
/*
 types shared by the priority-select register and its arbiter.
 assumes the constants header is on the include path.
*/
`include "cips_defs.svh"
package cips_pkg;
   typedef logic [`CIPS_NUM_SRC-1:0] cips_src_t;
   typedef logic [2:0] cips_idx_t;
   typedef enum logic [1:0] {
      CIPS_LVL_NONE,
      CIPS_LVL_LOW,
      CIPS_LVL_HIGH
   } cips_lvl_t;
endpackage

// >>> src/cips_arbiter.sv
/*
 picks the winning source among enabled pending requests, given the
 priority-select bits. assumes requests are already masked by the enables.
 lower index wins within a level, as in the fixed polling order.
*/
`timescale 1ns/10ps
`include "cips_defs.svh"
module cips_arbiter
   import cips_pkg::*;
#(
   parameter int NSRC = `CIPS_NUM_SRC
) (
   input wire cips_pkg::cips_src_t req, // masked pending requests
   input wire cips_pkg::cips_src_t high_sel, // per-source high level select
   output logic hi_any, // some high-level request pending
   output logic lo_any, // some low-level request pending
   output cips_pkg::cips_idx_t hi_idx, // winning high-level source
   output cips_pkg::cips_idx_t lo_idx // winning low-level source
);
   import cips_pkg::*;

   function automatic cips_idx_t first_set(input cips_src_t v);
      cips_idx_t r;
      r = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = cips_idx_t'(i);
         end
      end
      return r;
   endfunction

   always_comb begin
      hi_any = |(req & high_sel);
      lo_any = |(req & ~high_sel);
      hi_idx = first_set(req & high_sel);
      lo_idx = first_set(req & ~high_sel);
   end
endmodule // cips_arbiter

// >>> tb/cips_monitor.sv
/* port checker for the priority select block. assumes the top's port names. */
`timescale 1ns/10ps
`include "cips_defs.svh"
module cips_monitor
   import cips_pkg::*;
(
   input wire logic clock, // clock
   input wire logic rstn, // reset
   input wire logic [7:0] sfr_addr, // address
   input wire logic [7:0] sfr_page, // page
   input wire logic sfr_wr, // byte write
   input wire logic sfr_rd, // read
   input wire logic sfr_bit_wr, // bit write
   input wire logic [2:0] sfr_bit_sel, // bit number
   input wire logic [7:0] sfr_wdata, // data in
   input wire logic [7:0] sfr_rdata, // data out
   input wire logic sfr_hit, // read hit
   input wire cips_pkg::cips_src_t high_level, // levels
   input wire logic irq_take, // vector now
   input wire logic irq_ack, // vectored
   input wire logic irq_ret, // return
   input wire logic irq_is_high, // high winner
   input wire cips_pkg::cips_lvl_t active_lvl // in service
);
   wire hit_c = sfr_addr == `CIPS_SFR_ADDR && sfr_page == `CIPS_SFR_PAGE;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   a_read_hit: assert property (sfr_rd && hit_c |=> sfr_hit) else $error("no hit");
   a_miss_quiet: assert property (sfr_rd && !hit_c |=> !sfr_hit && sfr_rdata == 8'h00)
      else $error("miss answered");
   a_fixed_one: assert property (sfr_hit |-> sfr_rdata[7]) else $error("bit 7 low");
   a_level_copy: assert property (sfr_wr && hit_c ##1 !(sfr_wr || sfr_bit_wr)
      |=> high_level == $past(sfr_wdata[6:0], 2)) else $error("bad levels");
   a_bit_set: assert property (sfr_bit_wr && !sfr_wr && hit_c && sfr_bit_sel != 3'h7
      ##1 !(sfr_wr || sfr_bit_wr) |=> high_level[$past(sfr_bit_sel, 2)] == $past(sfr_wdata[0], 2))
      else $error("bad bit write");
   a_high_blocks: assert property (active_lvl == CIPS_LVL_HIGH |-> !irq_take)
      else $error("preempted high");
   a_low_nests: assert property (active_lvl == CIPS_LVL_LOW && irq_take |-> irq_is_high)
      else $error("low preempted low");
   a_ack_nests: assert property (irq_ack && irq_is_high ##1 !irq_ret
      |=> active_lvl == CIPS_LVL_HIGH) else $error("no high level");
   cover property (sfr_hit);
   cover property (sfr_bit_wr && hit_c);
   cover property (irq_take && irq_is_high && active_lvl == CIPS_LVL_LOW);
endmodule // cips_monitor
bind core_interrupt_priority_select cips_monitor mon (.*);

// >>> tb/cips_core_model.sv
/* core side model: acks each vector request, returns on command. assumes one clock. */
`timescale 1ns/10ps
module cips_core_model (
   input wire logic clock, // clock
   input wire logic rstn, // reset
   input wire logic irq_take, // vector request
   input wire logic ret_cmd, // bench asks return
   output logic irq_ack, // vector taken
   output logic irq_ret // return done
);
   // one ack per request so a held take never nests twice
   always_ff @(posedge clock) irq_ack <= rstn && irq_take && !irq_ack;
   always_ff @(posedge clock) irq_ret <= rstn && ret_cmd;
endmodule // cips_core_model

// >>> tb/testbench.sv
/* bench for the priority select block. assumes the core model and checker. */
`timescale 1ns/10ps
module testbench;
   import cips_pkg::*;
   logic clock, rstn, sfr_wr, sfr_rd, sfr_bit_wr, ret_cmd, irq_ack, irq_ret, sfr_hit, irq_take;
   logic irq_is_high;
   logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata;
   logic [2:0] sfr_bit_sel;
   cips_src_t irq_req, high_level;
   cips_idx_t irq_idx;
   cips_lvl_t active_lvl;
   int bad_count, n_compared, cycles;
   core_interrupt_priority_select dut (.*);
   cips_core_model core (.*);
   initial begin clock = 0; forever #5 clock = ~clock; end
   task end_of_test;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // the run needs under 400 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin bad_count++; end_of_test(); end
   end
   task chk(input logic [8:0] g, e);
      n_compared++;
      if (g !== e) begin bad_count++; $display("[FAIL] %0t got %h want %h", $time, g, e); end
   endtask
   task tick(input int n); repeat (n) @(posedge clock); #1; endtask
   task wr(input logic [7:0] a, p, d, input logic bw, input logic [2:0] b);
      tick(1);
      {sfr_addr, sfr_page, sfr_wdata, sfr_bit_wr, sfr_wr, sfr_bit_sel} = {a, p, d, bw, !bw, b};
      tick(1);
      {sfr_wr, sfr_bit_wr} = 2'h0;
   endtask
   task rd(input logic [7:0] a, p, e);
      tick(1);
      {sfr_addr, sfr_page, sfr_rd} = {a, p, 1'b1};
      tick(1);
      sfr_rd = 0;
      chk({sfr_hit, sfr_rdata}, {a == 8'hb8 && p == 8'h00, e});
   endtask
   initial begin
      {rstn, sfr_wr, sfr_rd, sfr_bit_wr, ret_cmd, sfr_addr, sfr_page, sfr_wdata, sfr_bit_sel} = 0;
      irq_req = 0;
      tick(5);
      rstn = 1;
      rd(8'hb8, 8'h00, 8'h80);
      wr(8'hb8, 8'h00, 8'h7f, 0, 0);
      rd(8'hb8, 8'h00, 8'hff);
      for (int i = 0; i < 7; i++) begin
         wr(8'hb8, 8'h00, 8'h00, 0, 0);
         wr(8'hb8, 8'h00, 8'h01, 1, i[2:0]);
         rd(8'hb8, 8'h00, 8'h80 | (8'h01 << i));
         chk(high_level, 9'(1 << i));
      end
      wr(8'hb8, 8'h00, 8'hff, 0, 0);
      wr(8'hb8, 8'h00, 8'h00, 1, 3);
      wr(8'hb8, 8'h00, 8'h00, 1, 7);
      wr(8'hb8, 8'h01, 8'h00, 0, 0);
      rd(8'hb9, 8'h00, 8'h00);
      rd(8'hb8, 8'h01, 8'h00);
      rd(8'hb8, 8'h00, 8'hf7);
      wr(8'hb8, 8'h00, 8'h10, 0, 0);
      irq_req = 7'h01;
      tick(6);
      chk(active_lvl, CIPS_LVL_LOW);
      irq_req = 7'h11;
      for (int k = 0; k < 8 && irq_take !== 1'b1; k++) tick(1);
      chk({irq_take, irq_is_high, irq_idx}, 9'h1c);
      tick(6);
      irq_req = 7'h01;
      chk(active_lvl, CIPS_LVL_HIGH);
      ret_cmd = 1;
      tick(1);
      ret_cmd = 0;
      tick(4);
      chk({irq_take, active_lvl}, CIPS_LVL_LOW);
      irq_req = 0;
      ret_cmd = 1;
      tick(1);
      ret_cmd = 0;
      tick(4);
      chk(active_lvl, CIPS_LVL_NONE);
      end_of_test();
   end
endmodule // testbench
